// ===== src/csk_pkg.sv
package csk_pkg;

  // Instruction word layout
  localparam int INSTR_WIDTH = 16;
  localparam int OPCODE_MSB = 15;
  localparam int OPCODE_LSB = 9;
  localparam int OPCODE_WIDTH = 7;
  localparam int BANK_SEL_BIT = 8;
  localparam int FILE_ADDR_MSB = 7;
  localparam int FILE_ADDR_LSB = 0;
  localparam int FILE_ADDR_WIDTH = 8;

  // Opcodes of the two compare-and-skip variants
  localparam logic [OPCODE_WIDTH-1:0] OPC_COMPARE_SKIP_GREATER = 7'h32;
  localparam logic [OPCODE_WIDTH-1:0] OPC_COMPARE_SKIP_LESS = 7'h30;

  // Data memory addressing
  localparam int DATA_WIDTH = 8;
  localparam int BANK_WIDTH = 4;
  localparam int DATA_ADDR_WIDTH = BANK_WIDTH + FILE_ADDR_WIDTH;
  localparam logic BANK_SEL_ACCESS = 1'b0;
  localparam logic [FILE_ADDR_WIDTH-1:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_WIDTH-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_WIDTH-1:0] ACCESS_HIGH_BANK = 4'hf;

  // Cycle count reported at completion
  localparam int CYCLE_COUNT_WIDTH = 2;
  localparam logic [CYCLE_COUNT_WIDTH-1:0] CYCLES_ONE = 2'h1;
  localparam logic [CYCLE_COUNT_WIDTH-1:0] CYCLES_ZERO = 2'h0;

  // Reset values
  localparam logic [DATA_ADDR_WIDTH-1:0] DATA_ADDR_RESET = 12'h000;
  localparam logic [DATA_WIDTH-1:0] OPERAND_RESET = 8'h00;

  typedef enum logic [1:0] {
    PHASE_Q1 = 2'b00,
    PHASE_Q2 = 2'b01,
    PHASE_Q3 = 2'b10,
    PHASE_Q4 = 2'b11
  } csk_phase_type;

  typedef enum logic [1:0] {
    STATE_EXEC = 2'b00,
    STATE_NOP_FIRST = 2'b01,
    STATE_NOP_SECOND = 2'b10
  } csk_state_type;

endpackage

// ===== src/csk_unsigned_compare.sv
`timescale 1ns/1ps
module csk_unsigned_compare
  import csk_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH
) (
  input wire logic [WIDTH-1:0] fileValue,
  input wire logic [WIDTH-1:0] workingValue,
  output logic fileGreater,
  output logic fileLess
);

  logic [WIDTH:0] difference;
  logic isZero;

  // Borrow out of the unsigned subtraction gives less-than
  always_comb begin
    difference = {1'b0, fileValue} - {1'b0, workingValue};
    isZero = (difference[WIDTH-1:0] == '0);
    fileLess = difference[WIDTH];
    fileGreater = !difference[WIDTH] && !isZero;
  end

endmodule

// ===== src/csk_compare_skip.sv
`timescale 1ns/1ps
// Summary of operation
// [RL1] Decode greater variant: 0110010, a, f
// [RL2] Decode less variant: 0110000, a, f
// [RL3] Unsigned subtract; modify no register or flag
// [RL4] Greater skips only if f exceeds W
// [RL5] Less skips only if f below W
// [RL6] Skip discards fetched word, one no-op cycle
// [RL7] Skipping a two-word instruction takes three cycles
// [RL8] Two whole no-op cycles, all phases idle
// [RL9] Bank bit zero uses the access bank
// [RL10] Bank bit one uses bank select register
// [RL11] Q1 decode, Q2 read, Q3 compare, Q4 idle
module csk_compare_skip
  import csk_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [INSTR_WIDTH-1:0] instrWord,
  input wire logic [DATA_WIDTH-1:0] workingRegister,
  input wire logic [BANK_WIDTH-1:0] bankSelectRegister,
  input wire logic [DATA_WIDTH-1:0] dataIn,
  input wire logic fetchedTwoWord,
  output logic [1:0] phase,
  output logic [DATA_ADDR_WIDTH-1:0] dataAddr,
  output logic dataRead,
  output logic compareBusy,
  output logic discardFetch,
  output logic skipTaken,
  output logic instrDone,
  output logic [CYCLE_COUNT_WIDTH-1:0] cycleCount
);

  function automatic logic opcodeIs(
    input logic [INSTR_WIDTH-1:0] word,
    input logic [OPCODE_WIDTH-1:0] pattern
  );
    opcodeIs = (word[OPCODE_MSB:OPCODE_LSB] == pattern);
  endfunction

  function automatic logic [DATA_ADDR_WIDTH-1:0] operandAddress(
    input logic [INSTR_WIDTH-1:0] word,
    input logic [BANK_WIDTH-1:0] bank
  );
    logic [FILE_ADDR_WIDTH-1:0] fileAddr;
    fileAddr = word[FILE_ADDR_MSB:FILE_ADDR_LSB];
    if (word[BANK_SEL_BIT] == BANK_SEL_ACCESS) begin
      // Access bank: low half of bank zero, high half of the top bank
      if (fileAddr < ACCESS_SPLIT) begin
        operandAddress = {ACCESS_LOW_BANK, fileAddr}; // RL9
      end else begin
        operandAddress = {ACCESS_HIGH_BANK, fileAddr}; // RL9
      end
    end else begin
      operandAddress = {bank, fileAddr}; // RL10
    end
  endfunction

  csk_phase_type phaseState;
  csk_state_type state;
  csk_state_type next_state;
  logic isGreater;
  logic isLess;
  logic decodeGreater;
  logic decodeLess;
  logic skipPending;
  logic twoWordPending;
  logic [DATA_WIDTH-1:0] operand;
  logic [CYCLE_COUNT_WIDTH-1:0] cycleTally;
  logic fileGreater;
  logic fileLess;
  logic skipDecision;
  logic endOfCycle;

  assign decodeGreater = opcodeIs(instrWord, OPC_COMPARE_SKIP_GREATER); // RL1
  assign decodeLess = opcodeIs(instrWord, OPC_COMPARE_SKIP_LESS); // RL2
  assign endOfCycle = (phaseState == PHASE_Q4);

  csk_unsigned_compare #(
    .WIDTH(DATA_WIDTH)
  ) u_compare (
    .fileValue(operand),
    .workingValue(workingRegister),
    .fileGreater(fileGreater),
    .fileLess(fileLess)
  );

  // Comparison result only; nothing is written back anywhere
  assign skipDecision = (isGreater && fileGreater) || (isLess && fileLess); // RL3 RL4 RL5

  // Four-phase instruction cycle sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      phaseState <= PHASE_Q1;
    end else begin
      unique case (phaseState)
        PHASE_Q1: phaseState <= PHASE_Q2;
        PHASE_Q2: phaseState <= PHASE_Q3;
        PHASE_Q3: phaseState <= PHASE_Q4;
        PHASE_Q4: phaseState <= PHASE_Q1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= PHASE_Q1;
    end else begin
      unique case (phaseState)
        PHASE_Q1: phase <= PHASE_Q2;
        PHASE_Q2: phase <= PHASE_Q3;
        PHASE_Q3: phase <= PHASE_Q4;
        PHASE_Q4: phase <= PHASE_Q1;
      endcase
    end
  end

  // Q1: decode; instructions are ignored during no-op cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      isGreater <= 1'b0;
      isLess <= 1'b0;
      compareBusy <= 1'b0;
    end else if (phaseState == PHASE_Q1) begin
      isGreater <= instrValid && (state == STATE_EXEC) && decodeGreater; // RL11
      isLess <= instrValid && (state == STATE_EXEC) && decodeLess; // RL11
      compareBusy <= instrValid && (state == STATE_EXEC) && (decodeGreater || decodeLess);
    end else if (endOfCycle) begin
      isGreater <= 1'b0;
      isLess <= 1'b0;
      compareBusy <= 1'b0;
    end
  end

  // Address presented from Q2; bank register sampled at decode
  always_ff @(posedge clock) begin
    if (rst) begin
      dataAddr <= DATA_ADDR_RESET;
    end else if (phaseState == PHASE_Q1 && instrValid && state == STATE_EXEC
                 && (decodeGreater || decodeLess)) begin
      dataAddr <= operandAddress(instrWord, bankSelectRegister); // RL9 RL10
    end
  end

  // Read strobe high for exactly the Q2 phase
  always_ff @(posedge clock) begin
    if (rst) begin
      dataRead <= 1'b0;
    end else begin
      dataRead <= (phaseState == PHASE_Q1) && instrValid && (state == STATE_EXEC)
                  && (decodeGreater || decodeLess); // RL11
    end
  end

  // Operand captured at the end of Q2, compared during Q3
  always_ff @(posedge clock) begin
    if (rst) begin
      operand <= OPERAND_RESET;
    end else if (phaseState == PHASE_Q2 && compareBusy) begin
      operand <= dataIn; // RL11
    end
  end

  // Q3: latch the decision; Q4 writes nothing
  always_ff @(posedge clock) begin
    if (rst) begin
      skipPending <= 1'b0;
    end else if (phaseState == PHASE_Q3) begin
      skipPending <= compareBusy && skipDecision; // RL11
    end else if (endOfCycle) begin
      skipPending <= 1'b0;
    end
  end

  // Size of the already fetched instruction, known by Q4
  always_ff @(posedge clock) begin
    if (rst) begin
      twoWordPending <= 1'b0;
    end else if (endOfCycle && state == STATE_EXEC) begin
      twoWordPending <= skipPending && fetchedTwoWord; // RL7
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      STATE_EXEC: begin
        if (skipPending) begin
          next_state = STATE_NOP_FIRST; // RL6
        end
      end
      STATE_NOP_FIRST: begin
        if (twoWordPending) begin
          next_state = STATE_NOP_SECOND; // RL7 RL8
        end else begin
          next_state = STATE_EXEC;
        end
      end
      STATE_NOP_SECOND: begin
        next_state = STATE_EXEC;
      end
      default: begin
        next_state = STATE_EXEC;
      end
    endcase
  end

  // States change only on instruction cycle boundaries
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= STATE_EXEC;
    end else if (endOfCycle) begin
      state <= next_state;
    end
  end

  // Whole cycles flagged so the fetched word executes as no-op
  always_ff @(posedge clock) begin
    if (rst) begin
      discardFetch <= 1'b0;
    end else if (endOfCycle) begin
      discardFetch <= (next_state != STATE_EXEC); // RL6 RL8
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      skipTaken <= 1'b0;
    end else begin
      skipTaken <= endOfCycle && (state == STATE_EXEC) && skipPending; // RL6
    end
  end

  // Running count of cycles spent by the current compare
  always_ff @(posedge clock) begin
    if (rst) begin
      cycleTally <= CYCLES_ZERO;
    end else if (endOfCycle) begin
      if (next_state == STATE_EXEC) begin
        cycleTally <= CYCLES_ZERO;
      end else begin
        cycleTally <= cycleTally + CYCLES_ONE; // RL7
      end
    end
  end

  // Completion pulse in Q1 after the last cycle, with the total
  always_ff @(posedge clock) begin
    if (rst) begin
      instrDone <= 1'b0;
      cycleCount <= CYCLES_ZERO;
    end else if (endOfCycle && next_state == STATE_EXEC
                 && (compareBusy || state != STATE_EXEC)) begin
      instrDone <= 1'b1;
      cycleCount <= cycleTally + CYCLES_ONE; // RL6 RL7
    end else begin
      instrDone <= 1'b0;
    end
  end

endmodule

// ===== tb/csk_compare_skip_checker.sv
`timescale 1ns/1ps
module csk_compare_skip_checker
  import csk_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [INSTR_WIDTH-1:0] instrWord,
  input wire logic [DATA_WIDTH-1:0] workingRegister,
  input wire logic [BANK_WIDTH-1:0] bankSelectRegister,
  input wire logic [DATA_WIDTH-1:0] dataIn,
  input wire logic fetchedTwoWord,
  input wire logic [1:0] phase,
  input wire logic [DATA_ADDR_WIDTH-1:0] dataAddr,
  input wire logic dataRead,
  input wire logic compareBusy,
  input wire logic discardFetch,
  input wire logic skipTaken,
  input wire logic instrDone,
  input wire logic [CYCLE_COUNT_WIDTH-1:0] cycleCount
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic atQ1 = phase == 2'h0 && instrValid;
  wire logic isCmp = instrWord[15:9] inside {OPC_COMPARE_SKIP_GREATER, OPC_COMPARE_SKIP_LESS};
  chk_phase_step: assert property (!$past(rst) |-> phase == $past(phase) + 2'h1)
    else $error("phase did not advance");
  chk_take_read: assert property (atQ1 && !discardFetch && isCmp |=> dataRead && compareBusy)
    else $error("compare not started");
  chk_word_ignored: assert property (atQ1 && (discardFetch || !isCmp) |=> !compareBusy)
    else $error("ignored word started a compare");
  chk_busy_span: assert property ($rose(compareBusy) |-> compareBusy [*3] ##1 !compareBusy)
    else $error("busy span wrong");
  chk_addr_bank: assert property (dataRead && $past(instrWord[8]) |->
    dataAddr == {$past(bankSelectRegister), $past(instrWord[7:0])})
    else $error("banked address wrong");
  chk_greater_skip: assert property (compareBusy && phase == 2'h2 &&
    $past(instrWord[15:9], 2) == OPC_COMPARE_SKIP_GREATER |->
    ##2 skipTaken == ($past(dataIn, 3) > $past(workingRegister, 2)))
    else $error("greater skip decision wrong");
  chk_less_skip: assert property (compareBusy && phase == 2'h2 &&
    $past(instrWord[15:9], 2) == OPC_COMPARE_SKIP_LESS |->
    ##2 skipTaken == ($past(dataIn, 3) < $past(workingRegister, 2)))
    else $error("less skip decision wrong");
  chk_nop_span: assert property (skipTaken |-> discardFetch [*4] ##1
    (discardFetch || instrDone && cycleCount == 2'h2))
    else $error("no-op cycle wrong");
  chk_three_cycles: assert property (instrDone && cycleCount == 2'h3 |->
    !$past(discardFetch, 9) && $past(discardFetch, 8) && $past(discardFetch) && !discardFetch)
    else $error("two no-op cycles missing");
  cover property (skipTaken);
  cover property (instrDone && cycleCount == 2'h3);
  cover property (instrDone && cycleCount == 2'h1);
endmodule

bind csk_compare_skip csk_compare_skip_checker u_csk_compare_skip_checker (.clock(clock), .rst(rst),
  .instrValid(instrValid), .instrWord(instrWord), .workingRegister(workingRegister),
  .bankSelectRegister(bankSelectRegister), .dataIn(dataIn), .fetchedTwoWord(fetchedTwoWord),
  .phase(phase), .dataAddr(dataAddr), .dataRead(dataRead), .compareBusy(compareBusy),
  .discardFetch(discardFetch), .skipTaken(skipTaken), .instrDone(instrDone), .cycleCount(cycleCount));

// ===== tb/csk_compare_skip_test.sv
`timescale 1ns/1ps
module csk_compare_skip_test;
  import csk_pkg::*;
  logic clock = 0, rst = 1, instrValid = 0, fetchedTwoWord = 0;
  logic [15:0] instrWord = '0;
  logic [7:0] workingRegister = '0, dataIn = '0;
  logic [3:0] bankSelectRegister = '0;
  logic [1:0] phase, cycleCount;
  logic [11:0] dataAddr;
  logic dataRead, compareBusy, discardFetch, skipTaken, instrDone;
  int fails = 0, num_checks = 0;
  logic [6:0] ops [4] = '{OPC_COMPARE_SKIP_GREATER, OPC_COMPARE_SKIP_LESS, 7'h31, 7'h00};

  csk_compare_skip u_csk_compare_skip (.clock(clock), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .workingRegister(workingRegister), .bankSelectRegister(bankSelectRegister),
    .dataIn(dataIn), .fetchedTwoWord(fetchedTwoWord), .phase(phase), .dataAddr(dataAddr),
    .dataRead(dataRead), .compareBusy(compareBusy), .discardFetch(discardFetch),
    .skipTaken(skipTaken), .instrDone(instrDone), .cycleCount(cycleCount));

  initial begin
    forever #25 clock = ~clock;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Access bank splits low half of bank 0 and high half of bank 15
  function automatic logic [11:0] addrOf(input logic a, input logic [7:0] f, input logic [3:0] b);
    if (a) return {b, f};
    return {f < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
  endfunction

  function automatic logic skipOf(input logic [6:0] op, input logic [7:0] d, input logic [7:0] w);
    if (op == OPC_COMPARE_SKIP_GREATER) return d > w;
    return op == OPC_COMPARE_SKIP_LESS && d < w;
  endfunction

  task automatic run(input logic [6:0] op, input logic a, input logic [7:0] f, input logic [7:0] w,
    input logic [7:0] d, input logic [3:0] b, input logic two);
    logic skip;
    int n, at, i;
    skip = skipOf(op, d, w);
    n = skip ? (two ? 3 : 2) : int'(op == OPC_COMPARE_SKIP_GREATER || op == OPC_COMPARE_SKIP_LESS);
    at = -1;
    i = 0;
    do begin
      @(negedge clock);
      i++;
    end while (phase !== 2'h3 && i < 9);
    if (phase !== 2'h3) begin
      fails++;
      test_done();
    end
    @(posedge clock);
    instrValid <= 1'b1;
    instrWord <= {op, a, f};
    workingRegister <= w;
    dataIn <= d;
    bankSelectRegister <= b;
    fetchedTwoWord <= two;
    for (i = 0; i < 16; i++) begin
      @(negedge clock);
      if (i == 1 && n > 0) check("dataAddr", dataAddr, addrOf(a, f, b));
      if (i == 1) check("dataRead", dataRead, n > 0);
      if (i == 1) check("phase", phase, 12'h1);
      if (i == 3) check("compareBusy", compareBusy, n > 0);
      if (i == 5) check("discardFetch", discardFetch, skip);
      if (i == 9) check("discardFetch2", discardFetch, skip && two);
      if (i == 4) check("skipTaken", skipTaken, skip);
      if (instrDone === 1'b1 && at < 0) begin
        at = i;
        check("cycleCount", cycleCount, 12'(n));
      end
      @(posedge clock);
      // Same word again in each no-op Q1: must not start a compare
      instrValid <= (i == 3 || i == 7 && two) && skip;
    end
    check("doneCycle", 12'(at), n > 0 ? 12'(4 * n) : 12'hfff);
  endtask

  initial begin
    void'($urandom(32'hab25));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    run(OPC_COMPARE_SKIP_GREATER, 1'b0, 8'h7f, 8'h10, 8'h10, 4'h3, 1'b0);
    run(OPC_COMPARE_SKIP_GREATER, 1'b0, 8'h80, 8'h00, 8'hff, 4'h3, 1'b1);
    run(OPC_COMPARE_SKIP_LESS, 1'b1, 8'h05, 8'hff, 8'h00, 4'ha, 1'b0);
    run(OPC_COMPARE_SKIP_LESS, 1'b1, 8'hff, 8'h00, 8'h00, 4'hf, 1'b1);
    run(7'h31, 1'b1, 8'h01, 8'h05, 8'h09, 4'h1, 1'b0);
    repeat (60) run(ops[$urandom % 4], 1'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
      4'($urandom), 1'($urandom));
    test_done();
  end
endmodule
